// ### rtl/bltf_pkg.sv
// Constants and types shared by the backplane link training framer.
package bltf_pkg;

  // Frame layout in line bit times, one bit per clock.
  localparam logic [12:0] FRAME_LEN     = 13'h1120;  // 4384
  localparam logic [12:0] MARK_ONES     = 13'h0010;  // 16
  localparam logic [12:0] MARK_LEN      = 13'h0020;  // 32
  localparam logic [12:0] CTRL_END      = 13'h0120;  // 288
  localparam logic [12:0] MARK_LAST     = 13'h001f;  // 31
  localparam logic [12:0] CTRL_LAST     = 13'h011f;  // 287
  localparam logic [12:0] TRAIN_LEN     = 13'h1000;  // 4096
  localparam logic [12:0] PRBS_LEN      = 13'h0ffe;  // 4094
  localparam logic [12:0] HOLD_BITS     = 13'h0120;  // 288, steady time for control inputs
  localparam int          FIELD_CELLS   = 16;
  localparam int          CELL_BITS     = 8;
  localparam logic [2:0]  CELL_MID      = 3'h4;
  localparam logic [31:0] MARKER        = 32'hffff0000;

  // Control field layout.
  localparam int          CF_PRESET     = 13;
  localparam int          CF_INIT       = 12;
  localparam int          SF_RX_READY   = 15;
  localparam logic [15:0] COEF_MASK     = 16'h303f;
  localparam logic [15:0] STAT_MASK     = 16'h803f;
  localparam logic [1:0]  REQ_HOLD      = 2'h0;
  localparam logic [1:0]  REQ_INC       = 2'h1;
  localparam logic [1:0]  REQ_DEC       = 2'h2;
  localparam logic [1:0]  UPD_NONE      = 2'h0;
  localparam logic [1:0]  UPD_MIN       = 2'h1;
  localparam logic [1:0]  UPD_DONE      = 2'h2;
  localparam logic [1:0]  UPD_MAX       = 2'h3;

  // Sequence generator.
  localparam logic [10:0] SEED_RST      = 11'h7ff;
  localparam logic [10:0] SEED_SAFE     = 11'h001;
  localparam int          PRBS_TAP_HI   = 10;
  localparam int          PRBS_TAP_LO   = 8;

  // Receive lock.
  localparam logic [1:0]  MISS_LIMIT    = 2'h3;
  localparam logic [7:0]  ERR_MAX       = 8'hff;

  // Register map, byte offsets.
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_SEED      = 8'h04;
  localparam logic [7:0]  REG_TX_COEF   = 8'h08;
  localparam logic [7:0]  REG_TX_STAT   = 8'h0c;
  localparam logic [7:0]  REG_RX_COEF   = 8'h10;
  localparam logic [7:0]  REG_RX_STAT   = 8'h14;
  localparam logic [7:0]  REG_STATUS    = 8'h18;
  localparam int          CTRL_TX_EN    = 0;
  localparam int          CTRL_SEED_LD  = 1;
  localparam int          ST_LOCK       = 0;
  localparam int          ST_ERR_LSB    = 8;

  typedef enum logic { BLTF_SEARCH, BLTF_LOCKED } bltf_lock_t;

endpackage

// ### rtl/bltf_top.sv
// Backplane link training framer: transmit frame builder, receive frame lock and AHB-Lite registers.
//
// Operation
// - Each transmitted frame is exactly 4384 bit times long.
// - Marker is sixteen ones then sixteen zeros.
// - Marker pattern never recurs later in the frame.
// - Coefficient and status fields each take 128 bit times, sixteen bits each.
// - Control fields go out most significant bit first.
// - Manchester cells toggle at an eighth of the line rate.
// - Reserved control bits sent as zero and ignored on receipt.
// - Coefficient bit 13 asks for preset coefficients.
// - Coefficient bit 12 asks for initial coefficients.
// - Three two-bit tap requests: 01 increment, 10 decrement, 00 hold.
// - Status bit 15 says the local receiver is ready.
// - Three two-bit tap states: 11 max, 01 min, 10 updated, 00 none.
// - Training sequence is 4094 pseudo-random bits plus two zeros.
// - Training bits go out at full line rate.
// - Generator loads an 11-bit seed on each control write with the seed-load bit set, then steps only on training bits.
// - Generator polynomial is one plus x^9 plus x^11.
// - Receiver searches for the marker and asserts frame lock on alignment.
// - Received control fields appear as outputs with transmit bit layout.
// - A Manchester error keeps the last good control fields until next good frame.
`timescale 1ns/1ps
`default_nettype none

module bltf_top (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             tx_bit,
  output logic             tx_sof,
  input  wire logic        rx_bit,
  output logic             frame_lock,
  output logic      [15:0] rx_coef,
  output logic      [15:0] rx_stat
);

  // All state sits in one record, so reset and registering each stay in one place.
  typedef struct packed {
    // Bus slave.
    logic                dp_act;
    logic                dp_wr;
    logic [7:0]          dp_addr;
    logic [31:0]         hrdata;
    // Software controls.
    logic                tx_en;
    logic [10:0]         seed;
    logic [15:0]         tx_coef;
    logic [15:0]         tx_stat;
    // Transmit.
    logic [12:0]         tcnt;
    logic [15:0]         coef_sh;
    logic [15:0]         stat_sh;
    logic                dme_lvl;
    logic [10:0]         lfsr;
    logic                tx_bit;
    logic                tx_sof;
    // Receive.
    bltf_pkg::bltf_lock_t lock;
    logic [31:0]         rsh;
    logic [12:0]         rpos;
    logic [1:0]          miss;
    logic                rerr;
    logic [31:0]         racc;
    logic [15:0]         rx_coef;
    logic [15:0]         rx_stat;
    logic [7:0]          err_cnt;
  } bltf_state_t;

  bltf_state_t s_r;
  bltf_state_t s_nxt;

  always_comb
  begin
    logic [12:0] tidx;
    logic [7:0]  tf;
    logic [3:0]  tbi;
    logic        td;
    logic        tb;
    logic        fb;
    logic [31:0] rsh_new;
    logic [7:0]  rf;
    logic        rerr_new;
    logic [31:0] rd;
    tidx     = 13'h0000;
    tf       = 8'h00;
    tbi      = 4'h0;
    td       = 1'b0;
    tb       = 1'b0;
    fb       = 1'b0;
    rsh_new  = 32'h00000000;
    rf       = 8'h00;
    rerr_new = 1'b0;
    rd       = 32'h00000000;
    // Every field holds unless a branch below gives it a new value.
    s_nxt    = s_r;
    s_nxt.tx_sof = 1'b0;

    // Register writes in the data phase.
    if (s_r.dp_act && s_r.dp_wr)
    begin
      unique case (s_r.dp_addr)
        bltf_pkg::REG_CTRL:
        begin
          s_nxt.tx_en = hwdata[bltf_pkg::CTRL_TX_EN];
        end
        bltf_pkg::REG_SEED:
        begin
          s_nxt.seed = hwdata[10:0];
        end
        bltf_pkg::REG_TX_COEF:
        begin
          s_nxt.tx_coef = hwdata[15:0];
        end
        bltf_pkg::REG_TX_STAT:
        begin
          s_nxt.tx_stat = hwdata[15:0];
        end
        default:
        begin
        end
      endcase
    end

    // Transmit frame builder.
    if (!s_r.tx_en)
    begin
      // Disabling restarts the count at the marker, so a re-enable never sends a cut frame.
      s_nxt.tcnt   = 13'h0000;
      s_nxt.tx_bit = 1'b0;
    end
    else
    begin
      if (s_r.tcnt == 13'h0000)
      begin
        s_nxt.tx_sof  = 1'b1;
        // Captured once per frame so a late change cannot tear a field.
        s_nxt.coef_sh = s_r.tx_coef & bltf_pkg::COEF_MASK;
        s_nxt.stat_sh = s_r.tx_stat & bltf_pkg::STAT_MASK;
      end
      // Positions are compared in rising order, so each branch below covers one part of the frame.
      if (s_r.tcnt < bltf_pkg::MARK_ONES)
      begin
        tb = 1'b1;
        s_nxt.dme_lvl = 1'b0;
      end
      else if (s_r.tcnt < bltf_pkg::MARK_LEN)
      begin
        tb = 1'b0;
        s_nxt.dme_lvl = 1'b0;
      end
      else if (s_r.tcnt < bltf_pkg::CTRL_END)
      begin
        tidx = s_r.tcnt - bltf_pkg::MARK_LEN;
        tf   = tidx[7:0];
        tbi  = 4'hf - tf[6:3];
        td   = tf[7] ? s_nxt.stat_sh[tbi] : s_nxt.coef_sh[tbi];
        // Cell edge every eight line bits, mid-cell edge for a one.
        if (tf[2:0] == 3'h0)
        begin
          s_nxt.dme_lvl = ~s_r.dme_lvl;
        end
        else if (tf[2:0] == bltf_pkg::CELL_MID && td)
        begin
          s_nxt.dme_lvl = ~s_r.dme_lvl;
        end
        tb = s_nxt.dme_lvl;
      end
      else
      begin
        tidx = s_r.tcnt - bltf_pkg::CTRL_END;
        if (tidx < bltf_pkg::PRBS_LEN)
        begin
          // The generator steps only on training bits, so the sequence runs on across frames.
          tb = s_r.lfsr[bltf_pkg::PRBS_TAP_HI];
          fb = s_r.lfsr[bltf_pkg::PRBS_TAP_HI] ^ s_r.lfsr[bltf_pkg::PRBS_TAP_LO];
          s_nxt.lfsr = {s_r.lfsr[9:0], fb};
        end
        else
        begin
          tb = 1'b0;
        end
      end
      s_nxt.tx_bit = tb;
      // One counter walks the whole frame, and every field is decoded from its position.
      if (s_r.tcnt == bltf_pkg::FRAME_LEN - 13'h0001)
      begin
        s_nxt.tcnt = 13'h0000;
      end
      else
      begin
        s_nxt.tcnt = s_r.tcnt + 13'h0001;
      end
    end

    // A zero seed would stall the generator and allow marker-like runs.
    if (s_r.dp_act && s_r.dp_wr && s_r.dp_addr == bltf_pkg::REG_CTRL && hwdata[bltf_pkg::CTRL_SEED_LD])
    begin
      s_nxt.lfsr = (s_nxt.seed == 11'h000) ? bltf_pkg::SEED_SAFE : s_nxt.seed;
    end

    // Receive marker search and lock.
    // Lock drops only after three missed markers, so one damaged marker costs no lock.
    rsh_new   = {s_r.rsh[30:0], rx_bit};
    s_nxt.rsh = rsh_new;
    if (s_r.rpos == bltf_pkg::FRAME_LEN - 13'h0001)
    begin
      s_nxt.rpos = 13'h0000;
    end
    else
    begin
      s_nxt.rpos = s_r.rpos + 13'h0001;
    end
    // The position counter runs freely; the marker search only re-anchors it.
    unique case (s_r.lock)
      bltf_pkg::BLTF_SEARCH:
      begin
        if (rsh_new == bltf_pkg::MARKER)
        begin
          s_nxt.lock = bltf_pkg::BLTF_LOCKED;
          s_nxt.rpos = bltf_pkg::MARK_LEN;
          s_nxt.miss = 2'h0;
        end
      end
      bltf_pkg::BLTF_LOCKED:
      begin
        if (s_r.rpos == bltf_pkg::MARK_LAST)
        begin
          if (rsh_new == bltf_pkg::MARKER)
          begin
            s_nxt.miss = 2'h0;
          end
          else if (s_r.miss == bltf_pkg::MISS_LIMIT - 2'h1)
          begin
            s_nxt.lock = bltf_pkg::BLTF_SEARCH;
            s_nxt.miss = 2'h0;
          end
          else
          begin
            s_nxt.miss = s_r.miss + 2'h1;
          end
        end
      end
    endcase

    // Manchester decode of the two control fields.
    // A cell must toggle at its start and may toggle again only at its middle.
    if (s_r.lock == bltf_pkg::BLTF_LOCKED && s_r.rpos >= bltf_pkg::MARK_LEN && s_r.rpos < bltf_pkg::CTRL_END)
    begin
      tidx     = s_r.rpos - bltf_pkg::MARK_LEN;
      rf       = tidx[7:0];
      rerr_new = (s_r.rpos == bltf_pkg::MARK_LEN) ? 1'b0 : s_r.rerr;
      if (rf[2:0] == 3'h0 && rx_bit == s_r.rsh[0])
      begin
        rerr_new = 1'b1;
      end
      else if (rf[2:0] != 3'h0 && rf[2:0] != bltf_pkg::CELL_MID && rx_bit != s_r.rsh[0])
      begin
        rerr_new = 1'b1;
      end
      if (rf[2:0] == bltf_pkg::CELL_MID)
      begin
        s_nxt.racc = {s_r.racc[30:0], rx_bit ^ s_r.rsh[0]};
      end
      s_nxt.rerr = rerr_new;
      if (s_r.rpos == bltf_pkg::CTRL_LAST)
      begin
        // A damaged frame is dropped whole rather than merged into the last good one.
        if (!rerr_new)
        begin
          s_nxt.rx_coef = s_nxt.racc[31:16] & bltf_pkg::COEF_MASK;
          s_nxt.rx_stat = s_nxt.racc[15:0] & bltf_pkg::STAT_MASK;
        end
        else if (s_r.err_cnt != bltf_pkg::ERR_MAX)
        begin
          s_nxt.err_cnt = s_r.err_cnt + 8'h01;
        end
      end
    end

    // Bus address phase; read data is registered for the data phase.
    // Only the low address byte is decoded, so the map repeats every 256 bytes.
    // The transfer size is not checked; narrow accesses act on the whole word.
    s_nxt.dp_act = 1'b0;
    s_nxt.dp_wr  = 1'b0;
    if (hready && hsel && htrans[1])
    begin
      s_nxt.dp_act  = 1'b1;
      s_nxt.dp_wr   = hwrite;
      s_nxt.dp_addr = haddr[7:0];
      if (!hwrite)
      begin
        unique case (haddr[7:0])
          bltf_pkg::REG_CTRL:
          begin
            rd[bltf_pkg::CTRL_TX_EN] = s_r.tx_en;
          end
          bltf_pkg::REG_SEED:
          begin
            rd[10:0] = s_r.seed;
          end
          bltf_pkg::REG_TX_COEF:
          begin
            rd[15:0] = s_r.tx_coef;
          end
          bltf_pkg::REG_TX_STAT:
          begin
            rd[15:0] = s_r.tx_stat;
          end
          bltf_pkg::REG_RX_COEF:
          begin
            rd[15:0] = s_r.rx_coef;
          end
          bltf_pkg::REG_RX_STAT:
          begin
            rd[15:0] = s_r.rx_stat;
          end
          bltf_pkg::REG_STATUS:
          begin
            rd[bltf_pkg::ST_LOCK]         = (s_r.lock == bltf_pkg::BLTF_LOCKED);
            rd[bltf_pkg::ST_ERR_LSB +: 8] = s_r.err_cnt;
          end
          default:
          begin
            rd = 32'h00000000;
          end
        endcase
      end
    end
    // Read data stands for one cycle only; it is zero whenever no read is in its data phase.
    s_nxt.hrdata = rd;
  end

  // Reset puts the generator at all ones, a legal nonzero start.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_r         <= '0;
      s_r.lock    <= bltf_pkg::BLTF_SEARCH;
      s_r.seed    <= bltf_pkg::SEED_RST;
      s_r.lfsr    <= bltf_pkg::SEED_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // The slave never stalls, so a read right after a write to the same word sees the old value.
  assign hrdata     = s_r.hrdata;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign tx_bit     = s_r.tx_bit;
  assign tx_sof     = s_r.tx_sof;
  assign frame_lock = (s_r.lock == bltf_pkg::BLTF_LOCKED);
  assign rx_coef    = s_r.rx_coef;
  assign rx_stat    = s_r.rx_stat;

endmodule // bltf_top

`default_nettype wire

// ### sim/bltf_properties.sv
// Concurrent checks on the framer's lane and received field ports.
`timescale 1ns/1ps
`default_nettype none

module bltf_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        tx_bit,
  input wire logic        tx_sof,
  input wire logic        rx_bit,
  input wire logic        frame_lock,
  input wire logic [15:0] rx_coef,
  input wire logic [15:0] rx_stat
);
  // Cells holding reserved bits: coefficient cells 0-1 and 4-9, status cells 17-25.
  localparam logic [31:0] RSV = 32'h03fe03f3;
  logic [12:0] pos_r;
  logic        have_r;
  logic [31:0] txh_r;
  logic [31:0] rxh_r;
  logic [12:0] off;
  logic [31:0] txw;
  logic        in_ctl;
  assign off    = pos_r - 13'h0020;
  assign txw    = {txh_r[30:0], tx_bit};
  assign in_ctl = have_r && !tx_sof && pos_r >= 13'h0020 && pos_r <= bltf_pkg::CTRL_LAST;
  // The count saturates, so a stopped transmitter never revisits in-frame positions.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pos_r  <= 13'h0000;
      have_r <= 1'b0;
    end
    else if (tx_sof)
    begin
      pos_r  <= 13'h0001;
      have_r <= 1'b1;
    end
    else if (pos_r != 13'h1fff)
      pos_r <= pos_r + 13'h0001;
    txh_r <= txw;
    rxh_r <= {rxh_r[30:0], rx_bit};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_frame_len; tx_sof && have_r |-> pos_r == bltf_pkg::FRAME_LEN; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_marker; have_r && !tx_sof && pos_r == bltf_pkg::MARK_LAST |-> txw == bltf_pkg::MARKER; endproperty
  a_marker: assert property (p_marker) else $error("marker wrong");
  property p_no_marker;
    have_r && !tx_sof && pos_r > bltf_pkg::MARK_LAST && pos_r < bltf_pkg::FRAME_LEN |-> txw != bltf_pkg::MARKER;
  endproperty
  a_no_marker: assert property (p_no_marker) else $error("marker repeated");
  property p_tail; have_r && !tx_sof && pos_r > 13'h111d && pos_r < 13'h1120 |-> !tx_bit; endproperty
  a_tail: assert property (p_tail) else $error("tail bit not zero");
  property p_cell_edge; in_ctl && pos_r[2:0] == 3'h0 |-> tx_bit != txh_r[0]; endproperty
  a_cell_edge: assert property (p_cell_edge) else $error("cell start lacks transition");
  property p_cell_quiet; in_ctl && pos_r[1:0] != 2'h0 |-> tx_bit == txh_r[0]; endproperty
  a_cell_quiet: assert property (p_cell_quiet) else $error("stray cell transition");
  property p_rsv_tx; in_ctl && pos_r[2:0] == 3'h4 && RSV[off[7:3]] |-> tx_bit == txh_r[0]; endproperty
  a_rsv_tx: assert property (p_rsv_tx) else $error("reserved bit sent as one");
  property p_lock; $rose(frame_lock) |-> rxh_r == bltf_pkg::MARKER; endproperty
  a_lock: assert property (p_lock) else $error("lock without marker");
  property p_rx_rsv;
    (rx_coef & ~bltf_pkg::COEF_MASK) == 16'h0000 && (rx_stat & ~bltf_pkg::STAT_MASK) == 16'h0000;
  endproperty
  a_rx_rsv: assert property (p_rx_rsv) else $error("reserved bit presented");
  property p_rx_upd; !$stable({rx_coef, rx_stat}) |-> frame_lock; endproperty
  a_rx_upd: assert property (p_rx_upd) else $error("fields changed while unlocked");
  c_sof: cover property (tx_sof);
  c_lock: cover property ($rose(frame_lock));
  c_unlock: cover property ($fell(frame_lock));
endmodule // bltf_props

bind bltf_top bltf_props u_props (
  .clk(clk), .rst_b(rst_b), .tx_bit(tx_bit), .tx_sof(tx_sof), .rx_bit(rx_bit),
  .frame_lock(frame_lock), .rx_coef(rx_coef), .rx_stat(rx_stat));
`default_nettype wire

// ### sim/bltf_lane_partner.sv
// Link partner model that returns the lane stream to the receiver.
`timescale 1ns/1ps
`default_nettype none

module bltf_lane_partner (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic lane_in,
  input  wire logic flip,
  output var logic  lane_out
);
  // Fields come back as sent, reserved bits, requests and states alike.
  // A flip inverts one line bit, which breaks a Manchester cell on purpose.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      lane_out <= 1'b0;
    else
      lane_out <= lane_in ^ flip;
  end
endmodule // bltf_lane_partner
`default_nettype wire

// ### sim/bltf_tb_top.sv
// Testbench for the backplane link training framer.
`timescale 1ns/1ps
`default_nettype none

module bltf_tb_top;
  logic        clk;
  logic        rst_b;
  logic        hsel;
  logic        hwrite;
  logic        flip;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic        tx_bit;
  logic        tx_sof;
  logic        rx_bit;
  logic        frame_lock;
  logic [15:0] rx_coef;
  logic [15:0] rx_stat;
  int          num_errors;
  int          cmp_count;

  bltf_top dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_bit(tx_bit), .tx_sof(tx_sof), .rx_bit(rx_bit), .frame_lock(frame_lock), .rx_coef(rx_coef),
    .rx_stat(rx_stat));
  bltf_lane_partner u_partner (.clk(clk), .rst_b(rst_b), .lane_in(tx_bit), .flip(flip), .lane_out(rx_bit));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_sof;
    do @(posedge clk); while (tx_sof !== 1'b1);
  endtask

  task automatic chk_frame(input logic [15:0] cf, input logic [15:0] sf, input logic [10:0] sd);
    logic [10:0] l;
    logic        v;
    logic        b;
    logic [15:0] f;
    int          c;
    l = sd;
    v = 1'b0;
    wait_sof();
    for (int p = 0; p < 4384; p++)
    begin
      if (p > 0)
        @(posedge clk);
      if (p < 32)
        b = (p < 16);
      else if (p < 288)
      begin
        c = (p - 32) / 8;
        f = (c < 16) ? cf : sf;
        if (p % 8 == 0)
          v = ~v;
        if (p % 8 == 4 && f[15 - c % 16])
          v = ~v;
        b = v;
      end
      else if (p < 4382)
      begin
        b = l[10];
        l = {l[9:0], l[10] ^ l[8]};
      end
      else
        b = 1'b0;
      chk("tx_bit", {31'h0, tx_bit}, {31'h0, b});
    end
    @(posedge clk);
    chk("tx_sof", {31'h0, tx_sof}, 32'h1);
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    {rst_b, hsel, hwrite, flip, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    ahb(1'b0, bltf_pkg::REG_SEED, 32'h0, q);
    chk("seed", q, {21'h0, bltf_pkg::SEED_RST});
    ahb(1'b0, bltf_pkg::REG_CTRL, 32'h0, q);
    chk("ctrl", q, 32'h0);
    ahb(1'b0, 8'h1c, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    ahb(1'b1, bltf_pkg::REG_SEED, 32'h5a3, q);
    ahb(1'b1, bltf_pkg::REG_TX_COEF, 32'hffd8, q);
    ahb(1'b1, bltf_pkg::REG_TX_STAT, 32'hffb9, q);
    ahb(1'b1, bltf_pkg::REG_CTRL, 32'h3, q);
    chk_frame(16'hffd8 & bltf_pkg::COEF_MASK, 16'hffb9 & bltf_pkg::STAT_MASK, 11'h5a3);
    $display("test tx_frame done");
    chk("lock", {31'h0, frame_lock}, 32'h1);
    chk("rx_coef", {16'h0, rx_coef}, 32'h3018);
    chk("rx_stat", {16'h0, rx_stat}, 32'h8039);
    ahb(1'b0, bltf_pkg::REG_RX_COEF, 32'h0, q);
    chk("rx_coef_reg", q, 32'h3018);
    $display("test loopback done");
    repeat (300) @(posedge clk);
    ahb(1'b1, bltf_pkg::REG_TX_COEF, 32'h0024, q);
    ahb(1'b1, bltf_pkg::REG_TX_STAT, 32'h0030, q);
    wait_sof();
    repeat (40) @(posedge clk);
    flip <= 1'b1;
    @(posedge clk);
    flip <= 1'b0;
    wait_sof();
    chk("rx_coef_hold", {16'h0, rx_coef}, 32'h3018);
    ahb(1'b0, bltf_pkg::REG_STATUS, 32'h0, q);
    chk("status", q, 32'h0101);
    repeat (300) @(posedge clk);
    chk("rx_coef_new", {16'h0, rx_coef}, 32'h0024);
    chk("rx_stat_new", {16'h0, rx_stat}, 32'h0030);
    $display("test dme_error done");
    ahb(1'b1, bltf_pkg::REG_SEED, 32'h0, q);
    ahb(1'b0, bltf_pkg::REG_SEED, 32'h0, q);
    chk("seed_zero", q, 32'h0);
    wait_sof();
    // The load lands on the tail bits, after the last training bit of this frame.
    repeat (4379) @(posedge clk);
    ahb(1'b1, bltf_pkg::REG_CTRL, 32'h3, q);
    chk_frame(16'h0024, 16'h0030, bltf_pkg::SEED_SAFE);
    $display("test zero_seed done");
    // Stopping inside the marker or the fields would trip the frame checks.
    repeat (300) @(posedge clk);
    ahb(1'b1, bltf_pkg::REG_CTRL, 32'h0, q);
    repeat (4) @(posedge clk);
    chk("tx_idle", {31'h0, tx_bit}, 32'h0);
    for (int i = 0; i < 20000 && frame_lock !== 1'b0; i++)
      @(posedge clk);
    chk("unlock", {31'h0, frame_lock}, 32'h0);
    $display("test lock_loss done");
    give_verdict();
  end
endmodule // bltf_tb_top
`default_nettype wire
